/* bench/boundary_scan_tap_decoder_test.sv */
`timescale 1ns/10ps
`include "bst_consts.svh"
module boundary_scan_tap_decoder_test;
   localparam int NP = 8;
   localparam int NI = 2;
   // Design ports
   logic clk;
   logic rst = 1'b1;
   logic tck, tms, tdi, tdo, tdo_oe, got;
   logic config_done, startup_clock_source, cfg_wr_valid, cfg_rd_strobe, startup_step;
   logic [31:0] usercode, cfg_wr_data, cfg_rd_data, word, d, p, wexp;
   logic user_chain_one_select, user_chain_two_select, user_chain_one_clock;
   logic user_chain_two_clock, user_chain_one_return, user_chain_two_return, user_tdi;
   logic user_reset_state, user_shift_state, user_update_state;
   logic [NP-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in, eo, eoe, ein;
   logic [NI-1:0] ded_in, ded_core_in;
   // Notes and counters
   logic [31:0] exp_q[$];
   int errors, checked, n1, n2, nwr, nrd, nst;
   bst_pkg::bst_instr_t bc[4];
   bst_tap #(.NP(NP), .NI(NI)) dut (.clk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe, .config_done,
      .startup_clock_source, .usercode, .cfg_wr_data, .cfg_wr_valid, .cfg_rd_data, .cfg_rd_strobe,
      .startup_step, .user_chain_one_select, .user_chain_two_select, .user_chain_one_clock,
      .user_chain_two_clock, .user_chain_one_return, .user_chain_two_return, .user_tdi,
      .user_reset_state, .user_shift_state, .user_update_state, .pad_in, .pad_out, .pad_oe,
      .core_out, .core_oe, .core_in, .ded_in, .ded_core_in);
   bst_tap_ctl jt (.tck, .tms, .tdi, .tdo, .word, .got);
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want)
      begin
         errors++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic results();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Instruction load notes the capture pattern
   task automatic ld(input bst_pkg::bst_instr_t c);
      exp_q.push_back(32'(`BST_IR_CAPTURE));
      jt.scan(1'b1, 5, 32'(c), 1'b1);
   endtask
   task automatic dr(input int n, input logic [31:0] v, input logic [31:0] e);
      exp_q.push_back(e);
      jt.scan(1'b0, n, v, 1'b1);
   endtask
   // Expected boundary capture
   function automatic logic [31:0] bnd(input logic [NP-1:0] o, input logic [NP-1:0] e);
      logic [31:0] b;
      b = '0;
      for (int i = 0; i < NP; i++)
         b[3*i +: 3] = {e[i], o[i], pad_in[i]};
      for (int j = 0; j < NI; j++)
         b[3*NP+j] = ded_in[j];
      return b;
   endfunction
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Scanned words against the oldest note
   always @(got)
      if (rst === 1'b0)
         check(word, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
   // Strobe counters, read away from the launching edge
   always @(negedge clk)
   begin
      nrd += (cfg_rd_strobe === 1'b1);
      nst += (startup_step === 1'b1);
      if (cfg_wr_valid === 1'b1)
      begin
         nwr++;
         check(cfg_wr_data, wexp);
      end
   end
   always @(posedge user_chain_one_clock) n1++;
   always @(posedge user_chain_two_clock) n2++;
   initial
   begin
      {config_done, startup_clock_source, user_chain_one_return, user_chain_two_return} = '0;
      {usercode, cfg_rd_data, pad_in, core_out, core_oe, ded_in} = '0;
      void'($urandom(32'h7d25));
      fork
         jt.tlr();
      join_none
      repeat (12) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      {usercode, cfg_rd_data, pad_in, core_out, core_oe, ded_in} = 90'({$urandom, $urandom,
         $urandom});
      user_chain_one_return = 1'($urandom);
      user_chain_two_return = ~user_chain_one_return;
      jt.tlr();
      dr(32, '0, {`BST_ID_VERSION, `BST_ID_FAMILY, `BST_ID_ROWS, `BST_ID_MAKER, 1'b1});
      ld(`BST_I_UCODE);
      dr(32, '0, `BST_UCODE_BLANK);
      bc = '{`BST_I_BYPASS, `BST_I_HIGHZ, 5'h1e, `BST_I_CHAIN_ONE};
      for (int k = 0; k < 4; k++)
      begin
         ld(bc[k]);
         check(32'(user_chain_one_select), 32'h0);
         if (k == 1)
            check(32'(pad_oe), 32'h0);
         d = $urandom;
         dr(32, d, {d[30:0], 1'b0});
      end
      @(negedge clk);
      config_done = 1'b1;
      ld(`BST_I_UCODE);
      dr(32, '0, usercode);
      for (int k = 0; k < 2; k++)
      begin
         ld(k ? `BST_I_CHAIN_TWO : `BST_I_CHAIN_ONE);
         check(32'({user_chain_two_select, user_chain_one_select}), k ? 32'h2 : 32'h1);
         n1 = 0;
         n2 = 0;
         dr(32, $urandom, {32{k ? user_chain_two_return : user_chain_one_return}});
         check(k ? n2 : n1, 32'd33);
         check(k ? n1 : n2, 32'd0);
      end
      // Boundary work only once configured
      p = $urandom & 32'h03ffffff;
      ld(`BST_I_SAMPLE);
      dr(26, p, bnd(core_out, core_oe));
      for (int i = 0; i < NP; i++)
         {eoe[i], eo[i], ein[i]} = p[3*i +: 3];
      ld(`BST_I_EXTEST);
      check(32'(pad_out), 32'(eo));
      check(32'(pad_oe), 32'(eoe));
      dr(26, p, bnd(core_out, core_oe));
      ld(`BST_I_INTEST);
      check(32'(core_in), 32'(ein));
      check(32'(ded_core_in), 32'(p[3*NP +: NI]));
      wexp = $urandom;
      ld(`BST_I_CFG_WR);
      jt.scan(1'b0, 32, wexp, 1'b0);
      repeat (10) @(posedge clk);
      check(nwr, 32'd1);
      ld(`BST_I_CFG_RD);
      jt.idle(4);
      dr(32, '0, cfg_rd_data);
      repeat (10) @(posedge clk);
      check(nrd, 32'd2);
      ld(`BST_I_START);
      jt.idle(6);
      @(negedge clk);
      startup_clock_source = 1'b1;
      jt.tlr();
      ld(`BST_I_START);
      jt.idle(6);
      repeat (10) @(posedge clk);
      check(nst, 32'd6);
      results();
   end
   // Hang guard
   initial
   begin
      #200us;
      errors++;
      results();
   end
endmodule

/* bench/bst_tap_assertions.sv */
`timescale 1ns/10ps
module bst_tap_assertions #(
   parameter int NP = 8,
   parameter int NI = 2
) (
   // Clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic tck,
   // Port and configuration side
   input wire logic tdi,
   input wire logic tdo_oe,
   input wire logic config_done,
   input wire logic startup_clock_source,
   input wire logic cfg_wr_valid,
   input wire logic startup_step,
   // User chain side
   input wire logic user_chain_one_select,
   input wire logic user_chain_two_select,
   input wire logic user_chain_one_clock,
   input wire logic user_chain_two_clock,
   input wire logic user_tdi,
   input wire logic user_reset_state,
   input wire logic user_shift_state,
   input wire logic user_update_state
);
   // Chain clocks only for the selected chain
   property p_gate1;
      @(posedge clk) disable iff (rst) !user_chain_one_select |-> !user_chain_one_clock;
   endproperty
   a_gate1: assert property (p_gate1) else $error("clock one unselected");
   property p_gate2;
      @(posedge clk) disable iff (rst) !user_chain_two_select |-> !user_chain_two_clock;
   endproperty
   a_gate2: assert property (p_gate2) else $error("clock two unselected");
   // No user chain before configuration
   property p_unconf;
      @(posedge clk) disable iff (rst)
         !config_done |-> !(user_chain_one_select || user_chain_two_select);
   endproperty
   a_unconf: assert property (p_unconf) else $error("select before done");
   // Shared data input and state flags
   property p_tdi;
      @(posedge clk) disable iff (rst) user_tdi == tdi;
   endproperty
   a_tdi: assert property (p_tdi) else $error("user data input differs");
   property p_flags;
      @(posedge tck) disable iff (rst)
         user_reset_state |-> !user_shift_state && !user_update_state;
   endproperty
   a_flags: assert property (p_flags) else $error("state flags overlap");
   property p_upd;
      @(posedge tck) disable iff (rst) user_update_state |=> !user_update_state;
   endproperty
   a_upd: assert property (p_upd) else $error("update flag too long");
   property p_shift;
      @(posedge tck) disable iff (rst) user_shift_state |-> tdo_oe;
   endproperty
   a_shift: assert property (p_shift) else $error("output off in shift");
   // Configuration write and start-up strobes
   property p_wr;
      @(posedge clk) disable iff (rst) cfg_wr_valid |=> !cfg_wr_valid;
   endproperty
   a_wr: assert property (p_wr) else $error("write pulse too long");
   property p_start;
      @(posedge clk) disable iff (rst)
         !startup_clock_source [*8] ##1 !startup_clock_source [*8] |-> !startup_step;
   endproperty
   a_start: assert property (p_start) else $error("step without source");
endmodule
bind bst_tap bst_tap_assertions #(.NP(NP), .NI(NI)) u_chk (.clk, .rst, .tck, .tdi, .tdo_oe,
   .config_done, .startup_clock_source, .cfg_wr_valid, .startup_step, .user_chain_one_select,
   .user_chain_two_select, .user_chain_one_clock, .user_chain_two_clock, .user_tdi,
   .user_reset_state, .user_shift_state, .user_update_state);

/* bench/bst_tap_ctl.sv */
`timescale 1ns/10ps
module bst_tap_ctl (
   // Test port
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo,
   // Scanned word and its toggle
   output logic [31:0] word,
   output logic got
);
   // Clock stands low between frames
   initial
   begin
      {tck, tdi, got} = '0;
      tms = 1'b1;
      word = '0;
   end
   // One clock: inputs set while low, output read before rise
   task automatic tick(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #16;
      o = tdo;
      tck = 1'b1;
      #16;
      tck = 1'b0;
   endtask
   // Clocks in idle
   task automatic idle(input int n);
      logic o;
      repeat (n) tick(1'b0, 1'b0, o);
   endtask
   // Five ones reach reset, then idle
   task automatic tlr();
      logic o;
      repeat (5) tick(1'b1, 1'b0, o);
      tick(1'b0, 1'b0, o);
   endtask
   // Scan from idle back to idle, low bit first
   task automatic scan(input logic ir, input int n, input logic [31:0] d, input logic en);
      logic o;
      logic [31:0] r;
      r = '0;
      tick(1'b1, 1'b0, o);
      if (ir)
         tick(1'b1, 1'b0, o);
      tick(1'b0, 1'b0, o);
      tick(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, d[i], o);
         r[i] = o;
      end
      tick(1'b1, 1'b0, o);
      tick(1'b0, 1'b0, o);
      if (en)
      begin
         word = r;
         got = ~got;
      end
   endtask
endmodule

/* logic/bst_consts.svh */
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH
`define BST_IR_W 5
`define BST_I_EXTEST 5'h00
`define BST_I_SAMPLE 5'h01
`define BST_I_CHAIN_ONE 5'h02
`define BST_I_CHAIN_TWO 5'h03
`define BST_I_CFG_RD 5'h04
`define BST_I_CFG_WR 5'h05
`define BST_I_INTEST 5'h07
`define BST_I_UCODE 5'h08
`define BST_I_IDCODE 5'h09
`define BST_I_HIGHZ 5'h0a
`define BST_I_START 5'h0c
`define BST_I_BYPASS 5'h1f
`define BST_IR_CAPTURE 5'h01
`define BST_WORD_W 32
`define BST_UCODE_BLANK 32'hffffffff
// Device code fields; values are arbitrary
`define BST_ID_VERSION 4'h1
`define BST_ID_FAMILY 7'h2c
`define BST_ID_ROWS 9'h020
`define BST_ID_MAKER 11'h35a
`endif

/* logic/bst_pkg.sv */
package bst_pkg;
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } bst_state_t;
   typedef logic [4:0] bst_instr_t;
endpackage

/* logic/bst_scan_access_primitive_chain.sv */
`timescale 1ns/10ps
module bst_scan_access_primitive_chain #(
   parameter int NP = 8,
   parameter int NI = 2
) (
   // Test clock and reset
   input wire logic tck,
   input wire logic rst,
   // Controller strobes and modes
   input wire logic capture,
   input wire logic shift,
   input wire logic update,
   input wire logic tdi,
   input wire logic drive_test,
   input wire logic core_test,
   input wire logic float_all,
   output logic so,
   // Pads
   input wire logic [NP-1:0] pad_in,
   output logic [NP-1:0] pad_out,
   output logic [NP-1:0] pad_oe,
   input wire logic [NP-1:0] core_out,
   input wire logic [NP-1:0] core_oe,
   output logic [NP-1:0] core_in,
   // Input-only dedicated pins
   input wire logic [NI-1:0] ded_in,
   output logic [NI-1:0] ded_core_in
);
   localparam int L = 3 * NP + NI;
   logic [L-1:0] sh_r;
   logic [L-1:0] sh_nxt;
   logic [L-1:0] upd_r;
   logic [L-1:0] upd_nxt;
   logic [L-1:0] cap;

   // Capture vector: pad group is in, out, enable from TDO end
   always_comb
   begin
      cap = '0;
      for (int p = 0; p < NP; p++)
      begin
         cap[3*p] = pad_in[p];
         cap[3*p+1] = core_out[p];
         cap[3*p+2] = core_oe[p];
      end
      for (int i = 0; i < NI; i++)
         cap[3*NP+i] = ded_in[i];
   end

   // Shift, capture and update registers
   always_comb
   begin
      sh_nxt = sh_r;
      upd_nxt = upd_r;
      if (capture)
         sh_nxt = cap;
      else if (shift)
         sh_nxt = {tdi, sh_r[L-1:1]};
      if (update)
         upd_nxt = sh_r;
      if (rst)
      begin
         sh_nxt = '0;
         upd_nxt = '0;
      end
   end

   always_ff @(posedge tck)
   begin
      sh_r <= sh_nxt;
      upd_r <= upd_nxt;
   end

   // Pad and core muxing, same for every pad
   always_comb
   begin
      so = sh_r[0];
      for (int p = 0; p < NP; p++)
      begin
         pad_out[p] = drive_test ? upd_r[3*p+1] : core_out[p];
         pad_oe[p] = float_all ? 1'b0 : (drive_test ? upd_r[3*p+2] : core_oe[p]);
         core_in[p] = core_test ? upd_r[3*p] : pad_in[p];
      end
      for (int i = 0; i < NI; i++)
         ded_core_in[i] = core_test ? upd_r[3*NP+i] : ded_in[i];
   end
endmodule

/* logic/bst_sync.sv */
`timescale 1ns/10ps
module bst_sync #(
   parameter int W = 1
) (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst,
   // Levels in and out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s1_nxt;
   logic [W-1:0] q_nxt;

   // Two stages; first one feeds only the second
   always_comb
   begin
      s1_nxt = d;
      q_nxt = s1_r;
      if (rst)
      begin
         s1_nxt = '0;
         q_nxt = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      s1_r <= s1_nxt;
      q <= q_nxt;
   end
endmodule

/* logic/bst_tap.sv */
`timescale 1ns/10ps
`include "bst_consts.svh"
module bst_tap #(
   parameter int NP = 8,
   parameter int NI = 2
) (
   // System clock and reset
   input wire logic clk,
   input wire logic rst,
   // Test port
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // Configuration side
   input wire logic config_done,
   input wire logic startup_clock_source,
   input wire logic [`BST_WORD_W-1:0] usercode,
   output logic [`BST_WORD_W-1:0] cfg_wr_data,
   output logic cfg_wr_valid,
   input wire logic [`BST_WORD_W-1:0] cfg_rd_data,
   output logic cfg_rd_strobe,
   output logic startup_step,
   // User scan chains
   output logic user_chain_one_select,
   output logic user_chain_two_select,
   output logic user_chain_one_clock,
   output logic user_chain_two_clock,
   input wire logic user_chain_one_return,
   input wire logic user_chain_two_return,
   output logic user_tdi,
   output logic user_reset_state,
   output logic user_shift_state,
   output logic user_update_state,
   // Pads
   input wire logic [NP-1:0] pad_in,
   output logic [NP-1:0] pad_out,
   output logic [NP-1:0] pad_oe,
   input wire logic [NP-1:0] core_out,
   input wire logic [NP-1:0] core_oe,
   output logic [NP-1:0] core_in,
   input wire logic [NI-1:0] ded_in,
   output logic [NI-1:0] ded_core_in
);
   localparam int WW = `BST_WORD_W;

   // Test clock domain state
   bst_pkg::bst_state_t state_r, state_nxt;
   bst_pkg::bst_instr_t ir_r, ir_nxt, irsh_r, irsh_nxt;
   logic [WW-1:0] dr_r, dr_nxt, wr_word_r, wr_word_nxt;
   logic byp_r, byp_nxt, chn1_r, chn1_nxt, chn2_r, chn2_nxt;
   logic fl_rst_r, fl_rst_nxt, fl_sh_r, fl_sh_nxt, fl_up_r, fl_up_nxt;
   logic wr_t_r, wr_t_nxt, rd_req_r, rd_req_nxt, st_t_r, st_t_nxt;
   logic tdo_nxt, tdo_oe_nxt, en1_r, en1_nxt, en2_r, en2_nxt;
   logic trst, done_t, src_t, ack_t, bs_so;
   logic [3:0] tsync;

   // System clock domain state
   logic [2:0] csync;
   logic [2:0] cseen_r, cseen_nxt;
   logic [WW-1:0] wr_data_r, wr_data_nxt, rd_hold_r, rd_hold_nxt;
   logic wr_v_r, wr_v_nxt, rd_s_r, rd_s_nxt, step_r, step_nxt;
   logic ack_r, ack_nxt;

   // User chain codes
   function automatic logic is_user(input bst_pkg::bst_instr_t c);
      is_user = (c == `BST_I_CHAIN_ONE) || (c == `BST_I_CHAIN_TWO);
   endfunction

   // Codes that drive pads from the boundary register
   function automatic logic is_pin_test(input bst_pkg::bst_instr_t c);
      is_pin_test = (c == `BST_I_EXTEST) || (c == `BST_I_INTEST);
   endfunction

   // Levels into the test clock domain
   bst_sync #(.W(4)) u_tsync (
      .clk(tck),
      .rst(1'b0),
      .d({rst, config_done, startup_clock_source, ack_r}),
      .q(tsync)
   );
   assign trst = tsync[3];
   assign done_t = tsync[2];
   assign src_t = tsync[1];
   assign ack_t = tsync[0];

   // Toggles into the system clock domain
   bst_sync #(.W(3)) u_csync (
      .clk(clk),
      .rst(rst),
      .d({wr_t_r, rd_req_r, st_t_r}),
      .q(csync)
   );

   // Boundary register
   bst_scan_access_primitive_chain #(.NP(NP), .NI(NI)) u_chain (
      .tck(tck),
      .rst(trst),
      .capture(state_r == bst_pkg::CAP_DR && (is_pin_test(ir_r) || ir_r == `BST_I_SAMPLE)),
      .shift(state_r == bst_pkg::SH_DR && (is_pin_test(ir_r) || ir_r == `BST_I_SAMPLE)),
      .update(state_r == bst_pkg::UPD_DR && (is_pin_test(ir_r) || ir_r == `BST_I_SAMPLE)),
      .tdi(tdi),
      .drive_test(is_pin_test(ir_r)),
      .core_test(ir_r == `BST_I_INTEST),
      .float_all(ir_r == `BST_I_HIGHZ),
      .so(bs_so),
      .pad_in(pad_in),
      .pad_out(pad_out),
      .pad_oe(pad_oe),
      .core_out(core_out),
      .core_oe(core_oe),
      .core_in(core_in),
      .ded_in(ded_in),
      .ded_core_in(ded_core_in)
   );

   // Controller, instruction and data registers
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         bst_pkg::TLR: state_nxt = tms ? bst_pkg::TLR : bst_pkg::RTI;
         bst_pkg::RTI: state_nxt = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
         bst_pkg::SEL_DR: state_nxt = tms ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
         bst_pkg::CAP_DR: state_nxt = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
         bst_pkg::SH_DR: state_nxt = tms ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
         bst_pkg::EX1_DR: state_nxt = tms ? bst_pkg::UPD_DR : bst_pkg::PAU_DR;
         bst_pkg::PAU_DR: state_nxt = tms ? bst_pkg::EX2_DR : bst_pkg::PAU_DR;
         bst_pkg::EX2_DR: state_nxt = tms ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
         bst_pkg::UPD_DR: state_nxt = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
         bst_pkg::SEL_IR: state_nxt = tms ? bst_pkg::TLR : bst_pkg::CAP_IR;
         bst_pkg::CAP_IR: state_nxt = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
         bst_pkg::SH_IR: state_nxt = tms ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
         bst_pkg::EX1_IR: state_nxt = tms ? bst_pkg::UPD_IR : bst_pkg::PAU_IR;
         bst_pkg::PAU_IR: state_nxt = tms ? bst_pkg::EX2_IR : bst_pkg::PAU_IR;
         bst_pkg::EX2_IR: state_nxt = tms ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
         bst_pkg::UPD_IR: state_nxt = tms ? bst_pkg::SEL_DR : bst_pkg::RTI;
      endcase

      irsh_nxt = irsh_r;
      ir_nxt = ir_r;
      dr_nxt = dr_r;
      byp_nxt = byp_r;
      wr_word_nxt = wr_word_r;
      wr_t_nxt = wr_t_r;
      rd_req_nxt = rd_req_r;
      st_t_nxt = st_t_r;

      // Instruction register
      if (state_r == bst_pkg::CAP_IR)
         irsh_nxt = `BST_IR_CAPTURE;
      else if (state_r == bst_pkg::SH_IR)
         irsh_nxt = {tdi, irsh_r[4:1]};
      if (state_r == bst_pkg::TLR)
         ir_nxt = `BST_I_IDCODE;
      else if (state_r == bst_pkg::UPD_IR)
      begin
         if (is_user(irsh_r) && !done_t)
            ir_nxt = `BST_I_BYPASS;
         else
            ir_nxt = irsh_r;
         if (irsh_r == `BST_I_CFG_RD)
            rd_req_nxt = ~rd_req_r;
      end

      // Word register and bypass bit
      if (state_r == bst_pkg::CAP_DR)
      begin
         byp_nxt = 1'b0;
         unique case (ir_r)
            `BST_I_IDCODE: dr_nxt = {`BST_ID_VERSION, `BST_ID_FAMILY,
               `BST_ID_ROWS, `BST_ID_MAKER, 1'b1};
            `BST_I_UCODE: dr_nxt = done_t ? usercode : `BST_UCODE_BLANK;
            `BST_I_CFG_RD: dr_nxt = (ack_t == rd_req_r) ? rd_hold_r : '0;
            default: dr_nxt = dr_r;
         endcase
      end
      else if (state_r == bst_pkg::SH_DR)
      begin
         dr_nxt = {tdi, dr_r[WW-1:1]};
         byp_nxt = tdi;
      end
      else if (state_r == bst_pkg::UPD_DR)
      begin
         if (ir_r == `BST_I_CFG_WR)
         begin
            wr_word_nxt = dr_r;
            wr_t_nxt = ~wr_t_r;
         end
         if (ir_r == `BST_I_CFG_RD)
            rd_req_nxt = ~rd_req_r;
      end

      // One start-up step per idle test clock
      if (state_r == bst_pkg::RTI && ir_r == `BST_I_START && src_t)
         st_t_nxt = ~st_t_r;

      // User chain selects and shared flags
      chn1_nxt = (ir_nxt == `BST_I_CHAIN_ONE);
      chn2_nxt = (ir_nxt == `BST_I_CHAIN_TWO);
      fl_rst_nxt = (state_nxt == bst_pkg::TLR);
      fl_sh_nxt = (state_nxt == bst_pkg::SH_DR);
      fl_up_nxt = (state_nxt == bst_pkg::UPD_DR);

      if (trst)
      begin
         state_nxt = bst_pkg::TLR;
         irsh_nxt = '0;
         ir_nxt = `BST_I_IDCODE;
         dr_nxt = '0;
         byp_nxt = 1'b0;
         wr_word_nxt = '0;
         wr_t_nxt = 1'b0;
         rd_req_nxt = 1'b0;
         st_t_nxt = 1'b0;
         chn1_nxt = 1'b0;
         chn2_nxt = 1'b0;
         fl_rst_nxt = 1'b1;
         fl_sh_nxt = 1'b0;
         fl_up_nxt = 1'b0;
      end
   end

   always_ff @(posedge tck)
   begin
      state_r <= state_nxt;
      irsh_r <= irsh_nxt;
      ir_r <= ir_nxt;
      dr_r <= dr_nxt;
      byp_r <= byp_nxt;
      wr_word_r <= wr_word_nxt;
      wr_t_r <= wr_t_nxt;
      rd_req_r <= rd_req_nxt;
      st_t_r <= st_t_nxt;
      user_chain_one_select <= chn1_nxt;
      user_chain_two_select <= chn2_nxt;
      user_reset_state <= fl_rst_nxt;
      user_shift_state <= fl_sh_nxt;
      user_update_state <= fl_up_nxt;
      chn1_r <= chn1_nxt;
      chn2_r <= chn2_nxt;
   end

   // Output mux, launched on the falling test clock edge
   always_comb
   begin
      tdo_oe_nxt = (state_r == bst_pkg::SH_DR) || (state_r == bst_pkg::SH_IR);
      en1_nxt = chn1_r && (state_r == bst_pkg::CAP_DR || state_r == bst_pkg::SH_DR);
      en2_nxt = chn2_r && (state_r == bst_pkg::CAP_DR || state_r == bst_pkg::SH_DR);
      if (state_r == bst_pkg::SH_IR)
         tdo_nxt = irsh_r[0];
      else
      begin
         unique case (ir_r)
            `BST_I_EXTEST, `BST_I_SAMPLE, `BST_I_INTEST: tdo_nxt = bs_so;
            `BST_I_CHAIN_ONE: tdo_nxt = user_chain_one_return;
            `BST_I_CHAIN_TWO: tdo_nxt = user_chain_two_return;
            `BST_I_IDCODE, `BST_I_UCODE, `BST_I_CFG_RD, `BST_I_CFG_WR: tdo_nxt = dr_r[0];
            default: tdo_nxt = byp_r;
         endcase
      end
      if (trst)
      begin
         tdo_oe_nxt = 1'b0;
         tdo_nxt = 1'b0;
         en1_nxt = 1'b0;
         en2_nxt = 1'b0;
      end
   end

   always_ff @(negedge tck)
   begin
      tdo <= tdo_nxt;
      tdo_oe <= tdo_oe_nxt;
      en1_r <= en1_nxt;
      en2_r <= en2_nxt;
   end

   // Gated chain clocks; enables change only while the test clock is low
   assign user_chain_one_clock = tck & en1_r;
   assign user_chain_two_clock = tck & en2_r;
   assign user_tdi = tdi;

   // System side: words and steps from toggle edges
   always_comb
   begin
      cseen_nxt = csync;
      wr_data_nxt = wr_data_r;
      rd_hold_nxt = rd_hold_r;
      ack_nxt = ack_r;
      wr_v_nxt = 1'b0;
      rd_s_nxt = 1'b0;
      step_nxt = 1'b0;
      if (csync[2] != cseen_r[2])
      begin
         wr_data_nxt = wr_word_r;
         wr_v_nxt = 1'b1;
      end
      if (csync[1] != cseen_r[1])
      begin
         rd_hold_nxt = cfg_rd_data;
         rd_s_nxt = 1'b1;
         ack_nxt = csync[1];
      end
      if (csync[0] != cseen_r[0])
         step_nxt = 1'b1;
      if (rst)
      begin
         cseen_nxt = '0;
         wr_data_nxt = '0;
         rd_hold_nxt = '0;
         ack_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      cseen_r <= cseen_nxt;
      wr_data_r <= wr_data_nxt;
      rd_hold_r <= rd_hold_nxt;
      ack_r <= ack_nxt;
      wr_v_r <= wr_v_nxt;
      rd_s_r <= rd_s_nxt;
      step_r <= step_nxt;
   end

   assign cfg_wr_data = wr_data_r;
   assign cfg_wr_valid = wr_v_r;
   assign cfg_rd_strobe = rd_s_r;
   assign startup_step = step_r;
endmodule
